// ==== include/dio_pkg.sv ====
// package: register map, field positions, reset values and widths for the digital i/o block
package dio_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int GROUPS = 2;
   localparam int PORTS_PER_GROUP = 3;
   localparam int PORT_W = 8;
   localparam int LINES = GROUPS * PORTS_PER_GROUP * PORT_W;
   localparam int NPORTS = GROUPS * PORTS_PER_GROUP;
   localparam int EXT_BIT = 3;
   // ----------------------------------------
   // register byte offsets (fourteen byte locations, one word each)
   // ----------------------------------------
   localparam logic [5:0] OFF_G0_PA = 6'h00;
   localparam logic [5:0] OFF_G0_PB = 6'h04;
   localparam logic [5:0] OFF_G0_PC = 6'h08;
   localparam logic [5:0] OFF_G0_CFG = 6'h0C;
   localparam logic [5:0] OFF_G1_PA = 6'h10;
   localparam logic [5:0] OFF_G1_PB = 6'h14;
   localparam logic [5:0] OFF_G1_PC = 6'h18;
   localparam logic [5:0] OFF_G1_CFG = 6'h1C;
   localparam logic [5:0] OFF_COS_EN = 6'h20;
   localparam logic [5:0] OFF_IRQ_STAT = 6'h24;
   localparam logic [5:0] OFF_IRQ_CLR = 6'h28;
   localparam logic [5:0] OFF_IRQ_EN = 6'h2C;
   localparam logic [5:0] OFF_BUF_CTL = 6'h30;
   localparam logic [5:0] OFF_COS_CLR = 6'h34;
   localparam int ADDR_W = 6;
   // ----------------------------------------
   // configuration register fields (bit set = input)
   // ----------------------------------------
   localparam int CFG_A_IN = 0;
   localparam int CFG_B_IN = 1;
   localparam int CFG_CLO_IN = 2;
   localparam int CFG_CHI_IN = 3;
   localparam int CFG_W = 4;
   localparam logic [3:0] CFG_RST = 4'hF; // all inputs after reset
   // ----------------------------------------
   // interrupt status fields
   // ----------------------------------------
   localparam int IRQ_COS = 0;
   localparam int IRQ_EXT0 = 1;
   localparam int IRQ_EXT1 = 2;
   localparam int IRQ_W = 3;
   localparam int BUF_EN_BIT = 0;
   localparam logic BUF_EN_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== include/dio_port_if.sv ====
// interface: one port group's direction and data between the top and the group module
`timescale 1ns/1ps
interface dio_port_if;
   import dio_pkg::*;
   logic [CFG_W-1:0] cfg;
   logic [PORTS_PER_GROUP*PORT_W-1:0] wrData;
   logic [PORTS_PER_GROUP*PORT_W-1:0] pinIn;
   logic [PORTS_PER_GROUP*PORT_W-1:0] rdData;
   logic [PORTS_PER_GROUP*PORT_W-1:0] pinOe;
   modport ctl (output cfg, output wrData, input rdData, input pinOe, output pinIn);
   modport grp (input cfg, input wrData, input pinIn, output rdData, output pinOe);
endinterface

// ==== rtl/dio_group.sv ====
// one parallel port unit: three 8-bit ports with per-port direction (per nibble on port c), output enables and read-back
`timescale 1ns/1ps
module dio_group
   import dio_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic bufEn,
   dio_port_if.grp port
);
   import dio_pkg::*;
   logic [PORTS_PER_GROUP*PORT_W-1:0] inQ;
   logic [PORTS_PER_GROUP*PORT_W-1:0] dirIn;

   // ----------------------------------------
   // direction per bit from the configuration
   // ----------------------------------------
   assign dirIn = {{4{port.cfg[CFG_CHI_IN]}}, {4{port.cfg[CFG_CLO_IN]}},
                   {PORT_W{port.cfg[CFG_B_IN]}}, {PORT_W{port.cfg[CFG_A_IN]}}};
   // buffers drive only output bits, and only while enabled
   assign port.pinOe = ~dirIn & {PORTS_PER_GROUP*PORT_W{bufEn}};

   // registered read: input bits show the sampled line, output bits the latch
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         inQ <= '0;
      end else begin
         inQ <= (port.pinIn & dirIn) | (port.wrData & ~dirIn);
      end
   end
   assign port.rdData = inQ;
endmodule

// ==== rtl/dio_top.sv ====
// top: 48-line digital i/o with change-of-state and edge interrupts behind an axi4-lite slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - there are 48 lines in two port units, each with 8-bit ports a, b and c.
// - each 8-bit port is set by software as input or as a latched output.
// - port c may be split so one nibble is input and the other is a latched output.
// - a change on any monitored input bit sets a latched interrupt request.
// - an enable register of six bits gates change detection per 8-bit port.
// - the change latch stays set until a software clear write removes it.
// - port c bit 3 of each group is an external interrupt input when its jumper is fitted.
// - a low-to-high edge on that bit raises an external interrupt request.
// - both group interrupts and the change interrupt are ored onto one host request.
// - buffer direction follows the direction programmed in each port's configuration.
// - with the right jumper, software may enable or tristate the line buffers.
// - fourteen consecutive register locations are decoded above the assigned base.
// - after reset no line is driven, so pull-ups hold the lines high.
// - the always-on jumper enables the buffers; the tristate jumper hands it to a bit.
// - each group's external interrupt is enabled only by its own jumper.
module dio_top
   import dio_pkg::*;
#(
   parameter int NUM_LINES = 48
)(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_LINES-1:0] linePinIn,
   output logic [NUM_LINES-1:0] linePinOut,
   output logic [NUM_LINES-1:0] linePinOe,
   input wire logic group0_external_irq_jumper,
   input wire logic group1_external_irq_jumper,
   input wire logic tristate_select_position,
   input wire logic buffer_always_on_position,
   output logic irqOut
);
   import dio_pkg::*;
   localparam int GW = PORTS_PER_GROUP * PORT_W;

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   if (NUM_LINES != LINES) begin : g_bad_width
      $error("dio_top: NUM_LINES must equal the fixed line count");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [GW-1:0] outLatch_q [GROUPS];
   logic [CFG_W-1:0] cfg_q [GROUPS];
   logic [NPORTS-1:0] cosEn_q;
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqEn_q;
   logic bufCtl_q;
   logic [NUM_LINES-1:0] sync1_q;
   logic [NUM_LINES-1:0] sync2_q;
   logic [NUM_LINES-1:0] prev_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic rValid_q;
   logic [31:0] rData_q;
   logic [1:0] rResp_q;

   // ----------------------------------------
   // port units
   // ----------------------------------------
   dio_port_if grpIf [GROUPS] ();
   logic bufEn;
   logic [GW-1:0] grpRd [GROUPS];

   // buffers on when the always-on jumper is fitted, else by the control bit while the tristate jumper is fitted
   assign bufEn = buffer_always_on_position |
                  (tristate_select_position & bufCtl_q);

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : g_grp
         assign grpIf[g].cfg = cfg_q[g];
         assign grpIf[g].wrData = outLatch_q[g];
         assign grpIf[g].pinIn = linePinIn[g*GW +: GW];
         assign grpRd[g] = grpIf[g].rdData;
         assign linePinOut[g*GW +: GW] = outLatch_q[g];
         assign linePinOe[g*GW +: GW] = grpIf[g].pinOe;
         dio_group u_grp (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .bufEn(bufEn),
            .port(grpIf[g].grp)
         );
      end
   endgenerate

   // ----------------------------------------
   // input synchroniser and previous sample
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= linePinIn;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // ----------------------------------------
   // event detection
   // ----------------------------------------
   logic [NPORTS-1:0] portChanged;
   logic [NPORTS-1:0] portIsIn;
   logic cosEvent;
   logic [GROUPS-1:0] extRise;
   logic [GROUPS-1:0] extJumper;
   logic [IRQ_W-1:0] irqEvent;

   assign extJumper = {group1_external_irq_jumper, group0_external_irq_jumper};
   generate
      for (g = 0; g < NPORTS; g++) begin : g_cos
         // a change counts on any port the software enabled that is set as input
         assign portChanged[g] = |(sync2_q[g*PORT_W +: PORT_W] ^ prev_q[g*PORT_W +: PORT_W]);
      end
      for (g = 0; g < GROUPS; g++) begin : g_ext
         assign portIsIn[g*3] = cfg_q[g][CFG_A_IN];
         assign portIsIn[g*3+1] = cfg_q[g][CFG_B_IN];
         assign portIsIn[g*3+2] = cfg_q[g][CFG_CLO_IN] | cfg_q[g][CFG_CHI_IN];
         // port c bit 3 rising edge, gated by this group's own jumper
         assign extRise[g] = extJumper[g] & sync2_q[g*GW+2*PORT_W+EXT_BIT] &
                             ~prev_q[g*GW+2*PORT_W+EXT_BIT];
      end
   endgenerate
   assign cosEvent = |(portChanged & cosEn_q & portIsIn);
   assign irqEvent = {extRise[1], extRise[0], cosEvent};

   // ----------------------------------------
   // axi4-lite decode
   // ----------------------------------------
   logic wrFire;
   logic rdFire;
   logic [ADDR_W-1:0] rdAddr;
   logic wrMapped;
   logic rdMapped;
   logic [31:0] rdWord;
   logic [31:0] wrMask;
   logic [IRQ_W-1:0] clrBits;

   assign s_axi_awready = ~awHeld_q & ~bValid_q;
   assign s_axi_wready = ~wHeld_q & ~bValid_q;
   assign s_axi_arready = ~rValid_q;
   assign wrFire = awHeld_q & wHeld_q & ~bValid_q;
   assign rdFire = s_axi_arvalid & s_axi_arready;
   assign rdAddr = s_axi_araddr[ADDR_W-1:0];
   assign wrMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   // only the fourteen word locations answer okay; others give slverr
   assign wrMapped = (awAddr_q[1:0] == 2'h0) && (awAddr_q <= OFF_COS_CLR);
   assign rdMapped = (rdAddr[1:0] == 2'h0) && (rdAddr <= OFF_COS_CLR);
   // a write to irq clear drops the named bits; a write to cos clear drops only the cos latch
   assign clrBits = !wrFire ? '0 :
                    (awAddr_q == OFF_IRQ_CLR) ? wData_q[IRQ_W-1:0] & wrMask[IRQ_W-1:0] :
                    (awAddr_q == OFF_COS_CLR) ? IRQ_W'(1 << IRQ_COS) : '0;

   // read mux: ports show registered pin samples for inputs, latch for outputs
   always_comb begin
      rdWord = 32'h0000_0000;
      unique case (rdAddr)
         OFF_G0_PA: rdWord[PORT_W-1:0] = grpRd[0][0 +: PORT_W];
         OFF_G0_PB: rdWord[PORT_W-1:0] = grpRd[0][PORT_W +: PORT_W];
         OFF_G0_PC: rdWord[PORT_W-1:0] = grpRd[0][2*PORT_W +: PORT_W];
         OFF_G0_CFG: rdWord[CFG_W-1:0] = cfg_q[0];
         OFF_G1_PA: rdWord[PORT_W-1:0] = grpRd[1][0 +: PORT_W];
         OFF_G1_PB: rdWord[PORT_W-1:0] = grpRd[1][PORT_W +: PORT_W];
         OFF_G1_PC: rdWord[PORT_W-1:0] = grpRd[1][2*PORT_W +: PORT_W];
         OFF_G1_CFG: rdWord[CFG_W-1:0] = cfg_q[1];
         OFF_COS_EN: rdWord[NPORTS-1:0] = cosEn_q;
         OFF_IRQ_STAT: rdWord[IRQ_W-1:0] = irqStat_q;
         OFF_IRQ_EN: rdWord[IRQ_W-1:0] = irqEn_q;
         OFF_BUF_CTL: rdWord[BUF_EN_BIT] = bufCtl_q;
         default: rdWord = 32'h0000_0000; // write-only and unmapped read zero
      endcase
   end

   // ----------------------------------------
   // write channel capture
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr[ADDR_W-1:0];
         end else if (wrFire) begin
            awHeld_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end else if (wrFire) begin
            wHeld_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // write response and read data
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
         rValid_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= RESP_OKAY;
      end else begin
         if (wrFire) begin
            bValid_q <= 1'b1;
            bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
         end
         if (rdFire) begin
            rValid_q <= 1'b1;
            rData_q <= rdWord;
            rResp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // ports start as inputs and buffers off so pull-ups hold the lines
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < GROUPS; i++) begin
            cfg_q[i] <= CFG_RST;
            outLatch_q[i] <= '0;
         end
         cosEn_q <= '0;
         irqEn_q <= '0;
         bufCtl_q <= BUF_EN_RST;
      end else if (wrFire && wStrb_q[0]) begin
         for (int i = 0; i < GROUPS; i++) begin
            if (awAddr_q == OFF_G0_PA + ADDR_W'(i*16))
               outLatch_q[i][0 +: PORT_W] <= wData_q[PORT_W-1:0];
            if (awAddr_q == OFF_G0_PB + ADDR_W'(i*16))
               outLatch_q[i][PORT_W +: PORT_W] <= wData_q[PORT_W-1:0];
            if (awAddr_q == OFF_G0_PC + ADDR_W'(i*16))
               outLatch_q[i][2*PORT_W +: PORT_W] <= wData_q[PORT_W-1:0];
            if (awAddr_q == OFF_G0_CFG + ADDR_W'(i*16))
               cfg_q[i] <= wData_q[CFG_W-1:0];
         end
         if (awAddr_q == OFF_COS_EN)
            cosEn_q <= wData_q[NPORTS-1:0];
         if (awAddr_q == OFF_IRQ_EN)
            irqEn_q <= wData_q[IRQ_W-1:0];
         if (awAddr_q == OFF_BUF_CTL)
            bufCtl_q <= wData_q[BUF_EN_BIT];
      end
   end

   // ----------------------------------------
   // sticky status: a new event wins over a clear in the same cycle
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqStat_q <= '0;
      end else begin
         irqStat_q <= (irqStat_q & ~clrBits) | irqEvent;
      end
   end

   // level request: any enabled latched source
   assign irqOut = |(irqStat_q & irqEn_q);
endmodule

// ==== test/dio_field_model.sv ====
// field side model: pull-ups on every line plus drivers the bench switches in
`timescale 1ns/1ps
module dio_field_model
   import dio_pkg::*;
(
   input wire logic [LINES-1:0] linePinOut,
   input wire logic [LINES-1:0] linePinOe,
   input wire logic [LINES-1:0] fieldVal,
   input wire logic [LINES-1:0] fieldEn,
   output logic [LINES-1:0] linePinIn
);
   // a released, undriven line floats up to the pull-up level
   assign linePinIn = (linePinOe & linePinOut) | (~linePinOe & (fieldVal | ~fieldEn));
endmodule

// ==== test/dio_top_properties.sv ====
// checker: bus answer, pin drive and interrupt timing properties of the i/o block
`timescale 1ns/1ps
module dio_properties
   import dio_pkg::*;
#(
   parameter int NUM_LINES = 48
)(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_LINES-1:0] linePinIn,
   input wire logic [NUM_LINES-1:0] linePinOut,
   input wire logic [NUM_LINES-1:0] linePinOe,
   input wire logic tristate_select_position,
   input wire logic buffer_always_on_position,
   input wire logic irqOut
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] wrAge_q;
   logic [3:0] pinAge_q;
   logic [NUM_LINES-1:0] pinPrev_q;
   // ages since the last write beat and pin change; outputs may only move shortly after one
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrAge_q <= 4'hF;
         pinAge_q <= 4'hF;
         pinPrev_q <= '0;
      end else begin
         wrAge_q <= (s_axi_wvalid && s_axi_wready) ? 4'h0 : wrAge_q + 4'(wrAge_q != 4'hF);
         pinAge_q <= (linePinIn != pinPrev_q) ? 4'h0 : pinAge_q + 4'(pinAge_q != 4'hF);
         pinPrev_q <= linePinIn;
      end
   end
   // ----------------------------------------
   // bus steps
   // ----------------------------------------
   sequence wrBeat;
      s_axi_wvalid && s_axi_wready;
   endsequence
   sequence badRead;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr > 32'h34 || s_axi_araddr[1:0] != 2'h0);
   endsequence
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
   a_write_answer: assert property (wrBeat |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
   a_bad_read: assert property (badRead |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)) else $error("unmapped read not refused");
   // ----------------------------------------
   // pins and interrupt
   // ----------------------------------------
   a_reset_quiet: assert property ($fell(sys_rst) |-> linePinOe == '0 && linePinOut == '0) else $error("lines driven after reset");
   a_oe_jumper: assert property (!tristate_select_position && !buffer_always_on_position |-> linePinOe == '0) else $error("drive without buffer jumper");
   a_latch_steady: assert property ($changed(linePinOut) |-> wrAge_q <= 4'h3) else $error("output latch moved without write");
   a_oe_follows_cfg: assert property ($changed(linePinOe) && $stable({tristate_select_position, buffer_always_on_position}) |-> wrAge_q <= 4'h3) else $error("direction moved without write");
   a_irq_sticky: assert property ($fell(irqOut) |-> wrAge_q <= 4'h3) else $error("interrupt fell without write");
   a_irq_cause: assert property ($rose(irqOut) |-> wrAge_q <= 4'h3 || pinAge_q <= 4'h6) else $error("interrupt rose without cause");
endmodule
bind dio_top dio_properties #(.NUM_LINES(NUM_LINES)) i_props (.*);

// ==== test/dio_top_test.sv ====
// bench: random register traffic, pin stimulus and interrupt checks for the i/o block
`timescale 1ns/1ps
module dio_top_test;
   import dio_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irqOut;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [LINES-1:0] linePinIn, linePinOut, linePinOe, outExp;
   logic [LINES-1:0] fieldVal = '0, fieldEn = '0;
   logic group0_external_irq_jumper = 1'b0, group1_external_irq_jumper = 1'b0;
   logic tristate_select_position = 1'b0, buffer_always_on_position = 1'b0;
   logic [31:0] seed = 32'hB5E2;
   logic [7:0] v;
   int errTotal = 0;
   int numChecks = 0;
   dio_top #(.NUM_LINES(LINES)) i_dut (.*);
   dio_field_model i_field (.*);
   always #2.5 core_clk = ~core_clk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // drive mask of one group: output-direction ports, when buffers are on
   function automatic logic [23:0] grpOe(input logic [3:0] c, input logic on);
      return on ? ~{{4{c[3]}}, {4{c[2]}}, {8{c[1]}}, {8{c[0]}}} : 24'h0;
   endfunction
   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      numChecks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         errTotal++;
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         errTotal++;
         endSim();
      end
   endtask
   // one write; address and data offered together, each released when taken
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= {26'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      // bready stays up between writes so the next call never reassigns it in this step
      tmo(n);
      chk("bresp", {46'h0, er}, {46'h0, s_axi_bresp});
   endtask
   task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= {26'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      // rready stays up between reads so the next call never reassigns it in this step
      tmo(n);
      chk(nm, {16'h0, e}, {16'h0, s_axi_rdata});
      chk("rresp", {46'h0, er}, {46'h0, s_axi_rresp});
   endtask
   task automatic idle();
      repeat (6) @(posedge core_clk);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      chk("oe", 48'h0, linePinOe);
      rd("cfg", OFF_G0_CFG, {28'h0, CFG_RST}, RESP_OKAY);
      $display("test reset done");
      // latched outputs with random data on all six ports
      tristate_select_position <= 1'b1;
      wr(OFF_BUF_CTL, 32'h1, RESP_OKAY);
      for (int g = 0; g < GROUPS; g++) begin
         wr(OFF_G0_CFG + 6'(16 * g), 32'h0, RESP_OKAY);
         for (int p = 0; p < PORTS_PER_GROUP; p++) begin
            v = 8'(xs());
            outExp[g * 24 + p * 8 +: 8] = v;
            wr(6'(16 * g + 4 * p), {24'h0, v}, RESP_OKAY);
            rd("port", 6'(16 * g + 4 * p), {24'h0, v}, RESP_OKAY);
         end
      end
      chk("out", outExp, linePinOut);
      chk("oe", {2{grpOe(4'h0, 1'b1)}}, linePinOe);
      $display("test outputs done");
      // buffer enable by control bit and by always-on jumper
      wr(OFF_BUF_CTL, 32'h0, RESP_OKAY);
      chk("oe off", 48'h0, linePinOe);
      buffer_always_on_position <= 1'b1;
      tristate_select_position <= 1'b0;
      @(posedge core_clk);
      chk("oe on", {2{grpOe(4'h0, 1'b1)}}, linePinOe);
      $display("test buffers done");
      // split port c and all-input group
      fieldVal <= {16'(xs()), xs()};
      fieldEn <= '1;
      wr(OFF_G0_CFG, 32'h8, RESP_OKAY);
      wr(OFF_G1_CFG, 32'hF, RESP_OKAY);
      chk("oe split", {grpOe(4'hF, 1'b1), grpOe(4'h8, 1'b1)}, linePinOe);
      rd("split", OFF_G0_PC, {24'h0, fieldVal[23:20], outExp[19:16]}, RESP_OKAY);
      for (int p = 0; p < PORTS_PER_GROUP; p++) begin
         rd("in", 6'(16 + 4 * p), {24'h0, fieldVal[24 + p * 8 +: 8]}, RESP_OKAY);
      end
      $display("test inputs done");
      // change of state on enabled and on disabled ports
      wr(OFF_IRQ_CLR, 32'h7, RESP_OKAY);
      wr(OFF_IRQ_EN, 32'h7, RESP_OKAY);
      wr(OFF_COS_EN, 32'h8, RESP_OKAY);
      fieldVal[32] <= ~fieldVal[32];
      idle();
      rd("cos off", OFF_IRQ_STAT, 32'h0, RESP_OKAY);
      fieldVal[24] <= ~fieldVal[24];
      idle();
      rd("cos", OFF_IRQ_STAT, 32'h1, RESP_OKAY);
      chk("irq", 48'h1, {47'h0, irqOut});
      idle();
      rd("cos held", OFF_IRQ_STAT, 32'h1, RESP_OKAY);
      wr(OFF_COS_CLR, 32'h0, RESP_OKAY);
      rd("cos clr", OFF_IRQ_STAT, 32'h0, RESP_OKAY);
      chk("irq", 48'h0, {47'h0, irqOut});
      $display("test change of state done");
      // rising edges on port c bit 3 gated per group jumper
      wr(OFF_COS_EN, 32'h0, RESP_OKAY);
      wr(OFF_G0_CFG, 32'hF, RESP_OKAY);
      group0_external_irq_jumper <= 1'b1;
      fieldVal[19] <= 1'b0;
      fieldVal[43] <= 1'b0;
      idle();
      wr(OFF_IRQ_CLR, 32'h7, RESP_OKAY);
      fieldVal[19] <= 1'b1;
      fieldVal[43] <= 1'b1;
      idle();
      rd("ext0", OFF_IRQ_STAT, 32'h2, RESP_OKAY);
      wr(OFF_IRQ_CLR, 32'h2, RESP_OKAY);
      group1_external_irq_jumper <= 1'b1;
      fieldVal[19] <= 1'b0;
      fieldVal[43] <= 1'b0;
      idle();
      rd("fall", OFF_IRQ_STAT, 32'h0, RESP_OKAY);
      fieldVal[43] <= 1'b1;
      idle();
      rd("ext1", OFF_IRQ_STAT, 32'h4, RESP_OKAY);
      wr(OFF_IRQ_EN, 32'h3, RESP_OKAY);
      @(posedge core_clk);
      chk("irq mask", 48'h0, {47'h0, irqOut});
      wr(OFF_IRQ_EN, 32'h4, RESP_OKAY);
      @(posedge core_clk);
      chk("irq on", 48'h1, {47'h0, irqOut});
      wr(OFF_IRQ_CLR, 32'h4, RESP_OKAY);
      @(posedge core_clk);
      chk("irq clr", 48'h0, {47'h0, irqOut});
      $display("test external done");
      // places outside the map
      rd("gap", 6'h38, 32'h0, RESP_SLVERR);
      rd("odd", 6'h05, 32'h0, RESP_SLVERR);
      wr(6'h3C, xs(), RESP_SLVERR);
      $display("test map done");
      endSim();
   end
endmodule
